// file: common/atsc_pkg.sv
// Constants and types for the converter trigger and sampling control block
package atsc_pkg;

	// ------------------------------------------------------------
	// Register map, byte addresses
	// ------------------------------------------------------------
	localparam logic [7:0] ADR_CTL = 8'h00;
	localparam logic [7:0] ADR_ANA = 8'h04;
	localparam logic [7:0] ADR_STS = 8'h08;
	localparam logic [7:0] ADR_MSK = 8'h0C;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 6;
	localparam int GLSW_BIT = 7;
	localparam int REQ_BIT = 8;
	localparam int HOLD_BIT = 9;
	localparam int UPD_BIT = 10;
	localparam int UPDIE_BIT = 11;
	localparam int SUSP_BIT = 12;
	localparam int REF_LSB = 13;
	localparam int REF_W = 3;
	localparam int DED_LSB = 0;
	localparam int NDED = 5;
	localparam int SHR_EN_BIT = 7;
	localparam int RDY_LSB = 16;
	localparam int WUP_LSB = 24;
	localparam int WUP_W = 4;
	localparam int NCONV = 6;
	localparam int SHR_IDX = 5;
	localparam int IRQ_UPD = 0;
	localparam int IRQ_WUP = 1;
	localparam int NIRQ = 2;
	localparam int CNT_W = 16;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam logic [SEL_W-1:0] SEL_RST = 6'h00;
	localparam logic [REF_W-1:0] REF_RST = 3'h0;
	localparam logic [WUP_W-1:0] WUP_RST = 4'h0;
	localparam logic [NCONV-1:0] EN_RST = 6'h00;
	localparam logic [NIRQ-1:0] STS_RST = 2'h0;
	localparam logic [NIRQ-1:0] MSK_RST = 2'h3;
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [31:0] DAT_RST = 32'h00000000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [NCONV-1:0] power_en;
		logic vref_pos_ext;
		logic vref_neg_ext;
		logic share_sample;
		logic manual_mode;
	} atsc_analog_t;

	typedef struct packed {
		logic [SEL_W-1:0] sel;
		logic glsw;
		logic req;
		logic hold;
		logic upd;
		logic updie;
		logic susp;
		logic [REF_W-1:0] ref_sel;
		logic [NCONV-1:0] ana_en;
		logic [WUP_W-1:0] wup;
		logic [NIRQ-1:0] sts;
		logic [NIRQ-1:0] msk;
	} atsc_state_t;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} atsc_wb_state_t;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic ready;
		logic en_d;
	} atsc_wup_state_t;

	// Warm-up length in clock cycles: two to the power of the count
	function automatic logic [CNT_W-1:0] wup_cycles(input logic [3:0] c);
		return 16'h0001 << c;
	endfunction : wup_cycles

endpackage : atsc_pkg

// file: rtl/atsc_wb_slave.sv
// Classic Wishbone slave front end with one wait state
`timescale 1ns/10ps
module atsc_wb_slave (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] rd_data_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wr_en_o
);
	atsc_pkg::atsc_wb_state_t st_r;
	atsc_pkg::atsc_wb_state_t st_nxt;

	// ------------------------------------------------------------
	// Acknowledge and read capture
	// ------------------------------------------------------------
	// Ack drops after one cycle so a held request is answered every second cycle
	always_comb begin
		st_nxt = st_r;
		st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
		if (st_nxt.ack) begin
			st_nxt.dat = wb_we_i ? atsc_pkg::DAT_RST : rd_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{ack: 1'b0, dat: atsc_pkg::DAT_RST};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Write lands on the same edge at which the master sees ack
	assign wr_en_o = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack;
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.dat;

endmodule : atsc_wb_slave

// file: rtl/atsc_warmup.sv
// Warm-up timer for one converter's analog and bias circuitry
`timescale 1ns/10ps
module atsc_warmup (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic en_i,
	input wire logic [3:0] count_i,
	output logic ready_o,
	output logic done_o
);
	atsc_pkg::atsc_wup_state_t st_r;
	atsc_pkg::atsc_wup_state_t st_nxt;

	// ------------------------------------------------------------
	// Count down after power-up
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.en_d = en_i;
		if (!en_i) begin
			st_nxt.cnt = atsc_pkg::CNT_RST;
			st_nxt.ready = 1'b0;
		end else if (!st_r.en_d) begin
			st_nxt.cnt = atsc_pkg::wup_cycles(count_i) - 16'h0001;
			st_nxt.ready = 1'b0;
		end else if (st_r.cnt != atsc_pkg::CNT_RST) begin
			st_nxt.cnt = st_r.cnt - 16'h0001;
		end else begin
			st_nxt.ready = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{cnt: atsc_pkg::CNT_RST, ready: 1'b0, en_d: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ready_o = st_r.ready;
	assign done_o = st_nxt.ready & ~st_r.ready;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// no use before warm-up
	warm_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(en_i) |-> !ready_o [*2])
		else $error("converter ready without warm-up");

	warm_power_a: assert property (@(posedge clk_i) disable iff (rst_i)
		ready_o |-> $past(en_i) && $past(st_r.cnt) == atsc_pkg::CNT_RST)
		else $error("converter ready while unpowered or counting");

	warm_done_c: cover property (@(posedge clk_i) disable iff (rst_i)
		$rose(ready_o));

endmodule : atsc_warmup

// file: rtl/atsc_ctrl.sv
// Trigger suspension, software sampling and analog enable control
`timescale 1ns/10ps
// How it works
// - Suspend blocks new conversion triggers, module stays enabled
// - Update-ready rise interrupts when its enable set
// - Update-ready reads one when reconfiguration safe
// - Update-ready needs suspend and no running conversion
// - Manual bit samples when set, holds when clear
// - Request bit converts the selected single input
// - Request bit clears itself next clock
// - Global level trigger drives inputs selecting it
// - Manual sampling overrides acquisition time setting
// - Manual sampling touches only shared converter inputs
// - Shared enable powers up, then warm-up count
// - Five dedicated enables, each with warm-up
// - Reference select picks supplies; top-bit codes reserved
module atsc_ctrl (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic irq_o,
	input wire logic [5:0] conv_busy_i,
	input wire logic [5:0] trig_req_i,
	output logic [5:0] conv_start_o,
	output logic single_req_o,
	output logic [5:0] req_input_sel_o,
	output logic glsw_level_o,
	output logic [5:0] warm_ready_o,
	output atsc_pkg::atsc_analog_t analog_o
);
	atsc_pkg::atsc_state_t st_r;
	atsc_pkg::atsc_state_t st_nxt;
	logic wr_en;
	logic [31:0] rd_data;
	logic [31:0] wval;
	logic [5:0] wup_done;
	logic [5:0] warm_ready;
	logic [1:0] sts_set;
	logic [1:0] sts_clr;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [31:0] wmerge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0] sel
	);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic [31:0] ctl_img(
		input atsc_pkg::atsc_state_t s
	);
		logic [31:0] r;
		r = 32'h00000000;
		r[atsc_pkg::SEL_LSB +: atsc_pkg::SEL_W] = s.sel;
		r[atsc_pkg::GLSW_BIT] = s.glsw;
		r[atsc_pkg::REQ_BIT] = s.req;
		r[atsc_pkg::HOLD_BIT] = s.hold;
		r[atsc_pkg::UPD_BIT] = s.upd;
		r[atsc_pkg::UPDIE_BIT] = s.updie;
		r[atsc_pkg::SUSP_BIT] = s.susp;
		r[atsc_pkg::REF_LSB +: atsc_pkg::REF_W] = s.ref_sel;
		return r;
	endfunction : ctl_img

	function automatic logic [31:0] ana_img(
		input atsc_pkg::atsc_state_t s,
		input logic [5:0] rdy
	);
		logic [31:0] r;
		r = 32'h00000000;
		r[atsc_pkg::DED_LSB +: atsc_pkg::NDED] =
			s.ana_en[atsc_pkg::NDED-1:0];
		r[atsc_pkg::SHR_EN_BIT] = s.ana_en[atsc_pkg::SHR_IDX];
		r[atsc_pkg::RDY_LSB +: atsc_pkg::NCONV] = rdy;
		r[atsc_pkg::WUP_LSB +: atsc_pkg::WUP_W] = s.wup;
		return r;
	endfunction : ana_img

	// ------------------------------------------------------------
	// Bus front end
	// ------------------------------------------------------------
	atsc_wb_slave u_bus (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.rd_data_i(rd_data),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.wr_en_o(wr_en)
	);

	// Unmapped addresses read zero; writes there are dropped
	always_comb begin
		case (wb_adr_i)
			atsc_pkg::ADR_CTL: rd_data = ctl_img(st_r);
			atsc_pkg::ADR_ANA: rd_data = ana_img(st_r, warm_ready);
			atsc_pkg::ADR_STS: rd_data = {30'h00000000, st_r.sts};
			atsc_pkg::ADR_MSK: rd_data = {30'h00000000, st_r.msk};
			default: rd_data = 32'h00000000;
		endcase
	end

	// ------------------------------------------------------------
	// Warm-up timers, one per converter
	// ------------------------------------------------------------
	for (genvar g = 0; g < atsc_pkg::NCONV; g++) begin : g_wup
		atsc_warmup u_wup (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.en_i(st_r.ana_en[g]),
			.count_i(st_r.wup),
			.ready_o(warm_ready[g]),
			.done_o(wup_done[g])
		);
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		wval = 32'h00000000;
		sts_clr = 2'h0;
		st_nxt.req = 1'b0;
		if (wr_en && wb_adr_i == atsc_pkg::ADR_CTL) begin
			wval = wmerge(ctl_img(st_r), wb_dat_i, wb_sel_i);
			st_nxt.sel = wval[atsc_pkg::SEL_LSB +: atsc_pkg::SEL_W];
			st_nxt.glsw = wval[atsc_pkg::GLSW_BIT];
			st_nxt.req = wval[atsc_pkg::REQ_BIT];
			st_nxt.hold = wval[atsc_pkg::HOLD_BIT];
			st_nxt.updie = wval[atsc_pkg::UPDIE_BIT];
			st_nxt.susp = wval[atsc_pkg::SUSP_BIT];
			if (!wval[atsc_pkg::REF_LSB + atsc_pkg::REF_W - 1]) begin
				st_nxt.ref_sel =
					wval[atsc_pkg::REF_LSB +: atsc_pkg::REF_W];
			end
		end
		if (wr_en && wb_adr_i == atsc_pkg::ADR_ANA) begin
			wval = wmerge(ana_img(st_r, warm_ready), wb_dat_i, wb_sel_i);
			st_nxt.ana_en[atsc_pkg::NDED-1:0] =
				wval[atsc_pkg::DED_LSB +: atsc_pkg::NDED];
			st_nxt.ana_en[atsc_pkg::SHR_IDX] =
				wval[atsc_pkg::SHR_EN_BIT];
			st_nxt.wup = wval[atsc_pkg::WUP_LSB +: atsc_pkg::WUP_W];
		end
		if (wr_en && wb_adr_i == atsc_pkg::ADR_MSK) begin
			wval = wmerge({30'h00000000, st_r.msk}, wb_dat_i, wb_sel_i);
			st_nxt.msk = wval[atsc_pkg::NIRQ-1:0];
		end
		if (wr_en && wb_adr_i == atsc_pkg::ADR_STS && wb_sel_i[0]) begin
			sts_clr = wb_dat_i[atsc_pkg::NIRQ-1:0];
		end
		st_nxt.upd = st_r.susp & ~|conv_busy_i;
		sts_set[atsc_pkg::IRQ_UPD] = st_nxt.upd & ~st_r.upd & st_r.updie;
		sts_set[atsc_pkg::IRQ_WUP] = |wup_done;
		// A set in the clearing cycle survives
		st_nxt.sts = (st_r.sts & ~sts_clr) | sts_set;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= '{
				sel: atsc_pkg::SEL_RST,
				glsw: 1'b0,
				req: 1'b0,
				hold: 1'b0,
				upd: 1'b0,
				updie: 1'b0,
				susp: 1'b0,
				ref_sel: atsc_pkg::REF_RST,
				ana_en: atsc_pkg::EN_RST,
				wup: atsc_pkg::WUP_RST,
				sts: atsc_pkg::STS_RST,
				msk: atsc_pkg::MSK_RST
			};
		end else begin
			st_r <= st_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs toward the converter cores
	// ------------------------------------------------------------
	// suspend gates every trigger
	assign conv_start_o = trig_req_i & warm_ready & {6{~st_r.susp}};
	assign single_req_o = st_r.req & ~st_r.susp;
	assign req_input_sel_o = st_r.sel;
	assign glsw_level_o = st_r.glsw & ~st_r.susp;
	assign warm_ready_o = warm_ready;
	always_comb begin
		analog_o.power_en = st_r.ana_en;
		analog_o.vref_pos_ext = st_r.ref_sel[0];
		analog_o.vref_neg_ext = st_r.ref_sel[1];
		analog_o.share_sample = st_r.hold;
		analog_o.manual_mode = st_r.hold;
	end
	// A set mask bit keeps its event off the line
	assign irq_o = |(st_r.sts & ~st_r.msk);

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	trig_blocked_a: assert property (
		st_r.susp |-> conv_start_o == 6'h00 && !single_req_o
			&& !glsw_level_o)
		else $error("trigger passed while suspended");

	upd_irq_a: assert property (
		!st_r.upd && st_nxt.upd && st_r.updie
			|=> st_r.sts[atsc_pkg::IRQ_UPD]
			&& (irq_o || st_r.msk[atsc_pkg::IRQ_UPD]))
		else $error("update-ready interrupt missing");

	upd_noirq_a: assert property (
		$rose(st_r.sts[atsc_pkg::IRQ_UPD]) |-> $past(st_r.updie))
		else $error("update-ready flagged with enable clear");

	upd_read_a: assert property (
		$rose(wb_ack_o) && !wb_we_i && wb_adr_i == atsc_pkg::ADR_CTL
			|-> wb_dat_o[atsc_pkg::UPD_BIT] == $past(st_r.upd))
		else $error("update-ready read back wrong");

	upd_cond_a: assert property (
		st_r.upd |-> $past(st_r.susp) && $past(conv_busy_i) == 6'h00)
		else $error("update-ready while running or not suspended");

	hold_pin_a: assert property (
		$rose(st_r.hold) |-> analog_o.share_sample [*1]
			##1 (analog_o.share_sample || $fell(st_r.hold)))
		else $error("sample-and-hold not following manual bit");

	req_pulse_a: assert property (
		$rose(single_req_o) |-> $past(wr_en)
			&& $past(wb_adr_i) == atsc_pkg::ADR_CTL
			&& req_input_sel_o == $past(st_nxt.sel))
		else $error("single request without a write");

	req_clear_a: assert property (
		st_r.req |=> !st_r.req)
		else $error("single request did not self-clear");

	glsw_lvl_a: assert property (
		st_r.glsw && !st_r.susp |-> glsw_level_o [*1]
			##1 (glsw_level_o || !st_r.glsw || st_r.susp))
		else $error("global trigger not driven");

	manual_mode_a: assert property (
		st_r.hold |-> analog_o.manual_mode && analog_o.share_sample)
		else $error("manual sampling not overriding timer");

	dedicated_free_a: assert property (
		$changed(st_r.hold) && !st_r.susp |-> conv_start_o[4:0]
			== (trig_req_i[4:0] & warm_ready[4:0]))
		else $error("manual sampling touched dedicated path");

	ref_reserved_a: assert property (
		wr_en && wb_adr_i == atsc_pkg::ADR_CTL && wb_sel_i[1]
			&& wb_dat_i[atsc_pkg::REF_LSB + atsc_pkg::REF_W - 1]
			|=> st_r.ref_sel == $past(st_r.ref_sel))
		else $error("reserved reference code accepted");

	warm_enable_a: assert property (
		$rose(st_r.ana_en[atsc_pkg::SHR_IDX])
			|-> !warm_ready[atsc_pkg::SHR_IDX] ##1
			!warm_ready[atsc_pkg::SHR_IDX])
		else $error("shared converter ready at once");

	trig_pass_a: assert property (
		!st_r.susp |-> conv_start_o == (trig_req_i & warm_ready))
		else $error("trigger dropped while not suspended");

	sts_sticky_a: assert property (
		st_r.sts[atsc_pkg::IRQ_UPD] && !sts_clr[atsc_pkg::IRQ_UPD]
			|=> st_r.sts[atsc_pkg::IRQ_UPD])
		else $error("update-ready status lost without a clear");

	irq_level_a: assert property (
		st_r.sts[atsc_pkg::IRQ_UPD] && !st_r.msk[atsc_pkg::IRQ_UPD]
			|-> irq_o)
		else $error("unmasked update-ready event not on the line");

	upd_set_a: assert property (
		st_r.susp && conv_busy_i == 6'h00 |=> st_r.upd)
		else $error("update-ready missing while safe");

	upd_drop_a: assert property (
		!st_r.susp |=> !st_r.upd)
		else $error("update-ready without suspend");

	upd_busy_a: assert property (
		conv_busy_i != 6'h00 |=> !st_r.upd)
		else $error("update-ready while a conversion runs");

	hold_clear_a: assert property (
		!st_r.hold
			|-> !analog_o.share_sample && !analog_o.manual_mode)
		else $error("sample-and-hold sampling with manual bit clear");

	req_idle_a: assert property (
		!(wr_en && wb_adr_i == atsc_pkg::ADR_CTL) |=> !st_r.req)
		else $error("single request without a control write");

	glsw_off_a: assert property (
		!st_r.glsw |-> !glsw_level_o)
		else $error("global trigger driven while clear");

	ref_legal_a: assert property (
		!st_r.ref_sel[atsc_pkg::REF_W-1])
		else $error("reserved reference code held");

	upd_rise_c: cover property ($rose(st_r.upd));
	single_req_c: cover property ($rose(single_req_o));
	warm_irq_c: cover property ($rose(st_r.sts[atsc_pkg::IRQ_WUP]));
	manual_then_req_c: cover property (
		$fell(st_r.hold) ##[1:20] $rose(single_req_o));

endmodule : atsc_ctrl

// file: sim/atsc_conv_model.sv
// Behavioural model of the converter cores behind the control block
`timescale 1ns/10ps
module atsc_conv_model #(
	parameter int BUSY_CYC = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [5:0] start_i,
	input wire logic single_i,
	output logic [5:0] busy_o
);
	// ------------------------------------------------------------
	// Conversion timers
	// ------------------------------------------------------------
	// Single requests land on the shared core, bit 5
	logic [7:0] cnt_r [6];
	always_ff @(posedge clk_i) begin
		for (int k = 0; k < 6; k++) begin
			if (rst_i) begin
				cnt_r[k] <= 8'h00;
			end else if (start_i[k] || (k == 5 && single_i)) begin
				cnt_r[k] <= 8'(BUSY_CYC);
			end else if (cnt_r[k] != 8'h00) begin
				cnt_r[k] <= cnt_r[k] - 8'h01;
			end
		end
	end
	always_comb begin
		for (int k = 0; k < 6; k++) begin
			busy_o[k] = (cnt_r[k] != 8'h00);
		end
	end
endmodule : atsc_conv_model

// file: sim/atsc_ctrl_bench.sv
// Self-checking bench for the trigger and sampling control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	num_errors++; $display("mismatch %s expected %h seen %h", nm, e, g); \
	end end
module atsc_ctrl_bench;
	// ------------------------------------------------------------
	// Signals
	// ------------------------------------------------------------
	typedef struct {
		logic [7:0] adr;
		logic [31:0] wd;
		logic [31:0] rd;
	} atsc_row_t;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_wdat = 32'h00000000;
	logic [3:0] wsel = 4'hF;
	logic [31:0] wb_rdat;
	logic wb_ack, irq;
	logic [5:0] busy, trig = 6'h00, start, sel_o, ready;
	logic single, glsw;
	atsc_pkg::atsc_analog_t ana;
	logic [31:0] rd;
	int num_errors = 0;
	int compares = 0;
	int hits = 0;
	atsc_row_t rows [8] = '{
		'{atsc_pkg::ADR_CTL, 32'h00000215, 32'h00000215},
		'{atsc_pkg::ADR_CTL, 32'h00006000, 32'h00006000},
		'{atsc_pkg::ADR_CTL, 32'h00000000, 32'h00000000},
		'{atsc_pkg::ADR_ANA, 32'h0F000000, 32'h0F000000},
		'{atsc_pkg::ADR_ANA, 32'h00000060, 32'h00000000},
		'{atsc_pkg::ADR_MSK, 32'h00000002, 32'h00000002},
		'{atsc_pkg::ADR_MSK, 32'hFFFFFFFF, 32'h00000003},
		'{8'h10, 32'hFFFFFFFF, 32'h00000000}};

	atsc_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
		.wb_ack_o(wb_ack), .irq_o(irq), .conv_busy_i(busy),
		.trig_req_i(trig), .conv_start_o(start), .single_req_o(single),
		.req_input_sel_o(sel_o), .glsw_level_o(glsw),
		.warm_ready_o(ready), .analog_o(ana));
	atsc_conv_model #(.BUSY_CYC(8)) cores (.clk_i(clk_i), .rst_i(rst_i),
		.start_i(start), .single_i(single), .busy_o(busy));

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		if (single === 1'b1) hits++;
	end

	// ------------------------------------------------------------
	// Bus cycles and closing
	// ------------------------------------------------------------
	task automatic wb_xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		wb_sel <= wsel;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack !== 1'b1 && n < 20);
		if (n >= 20) `CHK("bus ack", 1'b1, wb_ack)
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
	endtask : wb_xfer
	task automatic end_of_test;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : end_of_test
	initial begin
		repeat (5000) @(posedge clk_i);
		num_errors++;
		$display("mismatch watchdog expected finish seen hang");
		end_of_test();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb_xfer(1'b0, atsc_pkg::ADR_CTL, 32'h0);
		`CHK("ctl reset", 32'h00000000, rd)
		wb_xfer(1'b0, atsc_pkg::ADR_MSK, 32'h0);
		`CHK("mask reset", 32'h00000003, rd)
		for (int i = 0; i < 8; i++) begin
			wb_xfer(1'b1, rows[i].adr, rows[i].wd);
			wb_xfer(1'b0, rows[i].adr, 32'h0);
			`CHK("readback", rows[i].rd, rd)
		end
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00000200);
		#1 `CHK("sample", 2'b11, {ana.share_sample, ana.manual_mode})
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00000000);
		#1 `CHK("hold", 2'b00, {ana.share_sample, ana.manual_mode})
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h0000012A);
		repeat (3) @(posedge clk_i);
		`CHK("req pulse", 1, hits)
		`CHK("req sel", 6'h2A, sel_o)
		wb_xfer(1'b0, atsc_pkg::ADR_CTL, 32'h0);
		`CHK("req clear", 32'h0000002A, rd)
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00000080);
		#1 `CHK("glsw on", 1'b1, glsw)
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00002000);
		#1 `CHK("glsw off", 1'b0, glsw)
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h0000C000);
		#1 `CHK("vref", 2'b10, {ana.vref_pos_ext, ana.vref_neg_ext})
		// warm-up of 2^3 cycles on all cores
		wb_xfer(1'b1, atsc_pkg::ADR_ANA, 32'h0300009F);
		repeat (4) @(posedge clk_i);
		#1 `CHK("warm early", 6'h00, ready)
		`CHK("power", 6'h3F, ana.power_en)
		repeat (8) @(posedge clk_i);
		#1 `CHK("warm done", 6'h3F, ready)
		`CHK("irq masked", 1'b0, irq)
		wb_xfer(1'b0, atsc_pkg::ADR_ANA, 32'h0);
		`CHK("ana read", 32'h033F009F, rd)
		wb_xfer(1'b1, atsc_pkg::ADR_STS, 32'h00000003);
		// hardware triggers idle except when tested
		@(posedge clk_i);
		trig <= 6'h3F;
		#1 `CHK("start", 6'h3F, start)
		@(posedge clk_i);
		trig <= 6'h00;
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00001800);
		wb_xfer(1'b0, atsc_pkg::ADR_CTL, 32'h0);
		`CHK("upd busy", 32'h00001800, rd)
		repeat (10) @(posedge clk_i);
		wb_xfer(1'b0, atsc_pkg::ADR_CTL, 32'h0);
		`CHK("upd ready", 32'h00001C00, rd)
		wb_xfer(1'b0, atsc_pkg::ADR_STS, 32'h0);
		`CHK("upd status", 32'h00000001, rd)
		wb_xfer(1'b1, atsc_pkg::ADR_MSK, 32'h00000000);
		#1 `CHK("irq on", 1'b1, irq)
		wb_xfer(1'b1, atsc_pkg::ADR_STS, 32'h00000001);
		#1 `CHK("irq clear", 1'b0, irq)
		@(posedge clk_i);
		trig <= 6'h3F;
		#1 `CHK("suspended", 6'h00, start)
		@(posedge clk_i);
		trig <= 6'h00;
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00001100);
		repeat (3) @(posedge clk_i);
		`CHK("req blocked", 1, hits)
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00000000);
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'h00001000);
		repeat (3) @(posedge clk_i);
		wb_xfer(1'b0, atsc_pkg::ADR_STS, 32'h0);
		`CHK("no irq enable", 32'h00000000, rd)
		`CHK("irq quiet", 1'b0, irq)
		// Byte lane 0 only: the upper control byte keeps its value
		wsel = 4'h1;
		wb_xfer(1'b1, atsc_pkg::ADR_CTL, 32'hFFFFEF3F);
		wsel = 4'hF;
		wb_xfer(1'b0, atsc_pkg::ADR_CTL, 32'h0);
		`CHK("byte lane", 32'h0000143F, rd)
		// Mid-run reset brings every register back to its reset value
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 `CHK("rst ready", 6'h00, ready)
		`CHK("rst irq", 1'b0, irq)
		wb_xfer(1'b0, atsc_pkg::ADR_ANA, 32'h0);
		`CHK("rst ana", 32'h00000000, rd)
		wb_xfer(1'b0, atsc_pkg::ADR_MSK, 32'h0);
		`CHK("rst mask", 32'h00000003, rd)
		end_of_test();
	end
endmodule : atsc_ctrl_bench
